/* hdl/frt_pkg.sv */
// constants shared by the free-running capture/compare timer
package frt_pkg;

  // ------------------------------------------------------------
  // counter and compare values
  // ------------------------------------------------------------
  localparam logic [15:0] FRT_COUNT_RESET   = 16'hfffc; // reload and reset count
  localparam logic [15:0] FRT_COUNT_MAX     = 16'hffff; // last count before wrap
  localparam logic [15:0] FRT_COMPARE_RESET = 16'h8000; // compare register reset value
  localparam int          FRT_CHANNELS      = 2;        // capture and compare channels

  // ------------------------------------------------------------
  // timer clock select encoding
  // ------------------------------------------------------------
  localparam logic [1:0] FRT_CLK_DIV4 = 2'h0; // core clock / 4
  localparam logic [1:0] FRT_CLK_DIV2 = 2'h1; // core clock / 2
  localparam logic [1:0] FRT_CLK_DIV8 = 2'h2; // core clock / 8
  localparam logic [1:0] FRT_CLK_EXT  = 2'h3; // external count clock pin

  // prescaler terminal counts (divide ratio minus one)
  localparam logic [2:0] FRT_PRESC_DIV2 = 3'h1;
  localparam logic [2:0] FRT_PRESC_DIV4 = 3'h3;
  localparam logic [2:0] FRT_PRESC_DIV8 = 3'h7;

  // ------------------------------------------------------------
  // status byte bit positions
  // ------------------------------------------------------------
  localparam int FRT_ST_CAPTURE1 = 7;
  localparam int FRT_ST_COMPARE1 = 6;
  localparam int FRT_ST_WRAP     = 5;
  localparam int FRT_ST_CAPTURE2 = 4;
  localparam int FRT_ST_COMPARE2 = 3;

endpackage

/* hdl/frt_edge_sync.sv */
// two-flop pin synchroniser with rise and fall pulse detection
`timescale 1ns/1ps
`default_nettype none
module frt_edge_sync (
  input  wire logic core_clk,  // core clock
  input  wire logic rst_n,     // synchronous reset, active low
  input  wire logic ce,        // clock enable
  input  wire logic pinIn,     // asynchronous pin
  output logic      risePulse, // one cycle after a synced rise
  output logic      fallPulse  // one cycle after a synced fall
);

  // ------------------------------------------------------------
  // synchroniser and history
  // ------------------------------------------------------------
  logic syncFirst;  // first stage, read only by syncSecond
  logic syncSecond; // second stage, safe level
  logic syncLast;   // previous safe level

  // shift chain, frozen while ce is low
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      syncFirst  <= 1'b0;
      syncSecond <= 1'b0;
      syncLast   <= 1'b0;
    end else if (ce) begin
      syncFirst  <= pinIn;
      syncSecond <= syncFirst;
      syncLast   <= syncSecond;
    end
  end

  // edge pulses only qualify on an enabled cycle
  assign risePulse = ce & syncSecond & ~syncLast;
  assign fallPulse = ce & ~syncSecond & syncLast;

endmodule
`default_nettype wire

/* hdl/frt_timer.sv */
// 16-bit free-running timer with two capture and two compare channels
// Notes on behaviour
// - high byte read freezes low byte buffer
// - lone low read returns live low byte
// - wrap from max to zero sets flag
// - wrap interrupt needs enable and clear mask
// - wrap flag clears: status read, low access
// - shadow low access never clears wrap flag
// - runs in wait, holds count in halt
// - both select bits one picks external clock
// - edge polarity bit picks external active edge
// - capture edge copies count into capture register
// - capture sets flag, shared interrupt enable
// - capture flag clears: status read, low access
// - capture high read blocks captures until low
// - pins always live; modes allow channel two
// - compare registers software only, reset 8000h
// - match sets flag, drives pin, interrupts
// - compare flag clears: status read, low access
// - high write inhibits, low write re-enables, clears
// - divide-by-two matches equal, others equal plus one
// - pin disabled: general I/O, interrupt still possible
// - force bit copies level, no flag
// - internal clock is core divided 2/4/8
// - counter low write reloads FFFCh, reset too
`timescale 1ns/1ps
`default_nettype none
module frt_timer (
  input  wire logic       core_clk,           // core clock, 20 MHz
  input  wire logic       rst_n,              // synchronous reset, active low
  input  wire logic       ce,                 // clock enable, freezes all state
  input  wire logic       haltMode,           // high while the MCU is halted
  input  wire logic       globalIrqMask,      // global interrupt mask, high blocks
  input  wire logic       onePulseMode,       // one-pulse mode selected
  input  wire logic       pwmMode,            // pwm mode selected
  input  wire logic [1:0] timerClockSelect,   // timer clock source
  input  wire logic       extEdgePolarity,    // 1 rising, 0 falling ext edge
  input  wire logic [1:0] captureEdgeSelect,  // per channel, 1 rising, 0 falling
  input  wire logic       wrapIrqEnable,      // overflow interrupt enable
  input  wire logic       captureIrqEnable,   // shared capture interrupt enable
  input  wire logic       compareIrqEnable,   // shared compare interrupt enable
  input  wire logic [1:0] comparePinEnable,   // compare pin owned by the timer
  input  wire logic [1:0] compareOutputLevel, // level driven on match or force
  input  wire logic [1:0] forceLevelBit,      // pulse, force level onto pin
  input  wire logic       extCountClockPin,   // external count clock pin
  input  wire logic [1:0] captureInputPin,    // capture pins
  input  wire logic       statusRead,         // pulse, status byte read
  input  wire logic       countHighRead,      // pulse, counter high byte read
  input  wire logic       countLowRead,       // pulse, counter low byte read
  input  wire logic       countLowWrite,      // pulse, counter low byte write
  input  wire logic       shadowHighRead,     // pulse, shadow high byte read
  input  wire logic       shadowLowRead,      // pulse, shadow low byte read
  input  wire logic       shadowLowWrite,     // pulse, shadow low byte write
  input  wire logic [1:0] captureHighRead,    // pulses, capture high byte reads
  input  wire logic [1:0] captureLowRead,     // pulses, capture low byte reads
  input  wire logic [1:0] compareHighRead,    // pulses, compare high byte reads
  input  wire logic [1:0] compareLowRead,     // pulses, compare low byte reads
  input  wire logic [1:0] compareHighWrite,   // pulses, compare high byte writes
  input  wire logic [1:0] compareLowWrite,    // pulses, compare low byte writes
  input  wire logic [7:0] writeData,          // byte written with a write pulse
  output logic      [7:0] readData,           // byte of the last read
  output logic            readValid,          // pulse, readData updated
  output logic            wrapFlag,           // overflow flag
  output logic      [1:0] captureFlag,        // capture flags
  output logic      [1:0] compareFlag,        // compare flags
  output logic            timerIrq,           // timer interrupt request
  output logic      [1:0] compareOutputPin,   // compare pin latch
  output logic      [1:0] compareOutputOe     // high while timer drives the pin
);
  import frt_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [15:0] count;             // free-running counter
  logic [2:0]  prescale;          // internal prescaler
  logic [2:0]  prescaleTop;       // selected terminal count
  logic        tick;              // counter advance this cycle
  logic        countStep;         // counter advanced last cycle
  logic        extRise;           // synced external rise
  logic        extFall;           // synced external fall
  logic [1:0]  capRise;           // synced capture rises
  logic [1:0]  capFall;           // synced capture falls
  logic        lowAccess;         // any counter low byte access
  logic [7:0]  countLowBuf;       // frozen low byte, counter pair
  logic        countBufValid;     // counter pair read in progress
  logic [7:0]  shadowLowBuf;      // frozen low byte, shadow pair
  logic        shadowBufValid;    // shadow pair read in progress
  logic        wrapArmed;         // status seen with wrap flag set
  logic        wrapSet;           // counter wraps this cycle
  logic [15:0] captureValue [2];  // capture registers
  logic [1:0]  captureLock;       // high byte read, low pending
  logic [1:0]  captureArmed;      // status seen with capture flag set
  logic [1:0]  captureEvent;      // qualified capture this cycle
  logic [15:0] compareValue [2];  // compare registers
  logic [1:0]  compareInhibit;    // high written, low pending
  logic [1:0]  compareArmed;      // status seen with compare flag set
  logic [1:0]  compareMatch;      // match this cycle
  logic [7:0]  statusByte;        // assembled status byte

  // low byte of a word
  function automatic logic [7:0] lowByte(input logic [15:0] w);
    return w[7:0];
  endfunction

  // high byte of a word
  function automatic logic [7:0] highByte(input logic [15:0] w);
    return w[15:8];
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  frt_edge_sync extSync (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .pinIn     (extCountClockPin),
    .risePulse (extRise),
    .fallPulse (extFall)
  );

  frt_edge_sync capSync0 (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .pinIn     (captureInputPin[0]),
    .risePulse (capRise[0]),
    .fallPulse (capFall[0])
  );

  frt_edge_sync capSync1 (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .pinIn     (captureInputPin[1]),
    .risePulse (capRise[1]),
    .fallPulse (capFall[1])
  );

  // ------------------------------------------------------------
  // timer clock
  // ------------------------------------------------------------
  // prescaler terminal count from the clock select
  always_comb begin
    case (timerClockSelect)
      FRT_CLK_DIV2: prescaleTop = FRT_PRESC_DIV2;
      FRT_CLK_DIV8: prescaleTop = FRT_PRESC_DIV8;
      default:      prescaleTop = FRT_PRESC_DIV4;
    endcase
  end

  // prescaler, stopped in halt, untouched by wait
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prescale <= 3'h0;
    end else if (ce && !haltMode) begin
      if (prescale >= prescaleTop) begin
        prescale <= 3'h0;
      end else begin
        prescale <= prescale + 3'h1;
      end
    end
  end

  // external edges rely on the source staying under a quarter rate
  always_comb begin
    if (haltMode) begin
      tick = 1'b0;
    end else if (timerClockSelect == FRT_CLK_EXT) begin
      tick = extEdgePolarity ? extRise : extFall;
    end else begin
      tick = ce && (prescale >= prescaleTop);
    end
  end

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  assign lowAccess = countLowRead | countLowWrite;
  assign wrapSet   = tick && (count == FRT_COUNT_MAX) && !(countLowWrite || shadowLowWrite);

  // count advance and reload on a low byte write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count <= FRT_COUNT_RESET;
    end else if (ce) begin
      if (countLowWrite || shadowLowWrite) begin
        count <= FRT_COUNT_RESET;
      end else if (tick) begin
        count <= count + 16'h0001;
      end
    end
  end

  // marks the cycle in which a new count is visible
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      countStep <= 1'b0;
    end else if (ce) begin
      countStep <= tick;
    end
  end

  // ------------------------------------------------------------
  // two-byte read buffers
  // ------------------------------------------------------------
  // counter pair: first high read freezes the low byte
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      countLowBuf   <= 8'h00;
      countBufValid <= 1'b0;
    end else if (ce) begin
      if (countLowRead) begin
        countBufValid <= 1'b0;
      end else if (countHighRead && !countBufValid) begin
        countLowBuf   <= lowByte(count);
        countBufValid <= 1'b1;
      end
    end
  end

  // shadow pair behaves the same, independently
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shadowLowBuf   <= 8'h00;
      shadowBufValid <= 1'b0;
    end else if (ce) begin
      if (shadowLowRead) begin
        shadowBufValid <= 1'b0;
      end else if (shadowHighRead && !shadowBufValid) begin
        shadowLowBuf   <= lowByte(count);
        shadowBufValid <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // wrap flag
  // ------------------------------------------------------------
  // set wins over clear; only counter low access clears
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrapFlag  <= 1'b0;
      wrapArmed <= 1'b0;
    end else if (ce) begin
      if (wrapSet) begin
        wrapFlag <= 1'b1;
      end else if (wrapArmed && lowAccess) begin
        wrapFlag  <= 1'b0;
        wrapArmed <= 1'b0;
      end else if (statusRead && wrapFlag) begin
        wrapArmed <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // input capture
  // ------------------------------------------------------------
  // channel one is taken by one-pulse and pwm modes
  always_comb begin
    for (int i = 0; i < FRT_CHANNELS; i++) begin
      captureEvent[i] = (captureEdgeSelect[i] ? capRise[i] : capFall[i])
                        && !captureLock[i];
    end
    if (onePulseMode || pwmMode) begin
      captureEvent[0] = 1'b0;
    end
  end

  // capture registers, lock and flags per channel
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < FRT_CHANNELS; i++) begin
        captureValue[i] <= 16'h0000;
      end
      captureLock  <= 2'h0;
      captureFlag  <= 2'h0;
      captureArmed <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < FRT_CHANNELS; i++) begin
        if (captureEvent[i]) begin
          captureValue[i] <= count;
        end
        if (captureLowRead[i]) begin
          captureLock[i] <= 1'b0;
        end else if (captureHighRead[i]) begin
          captureLock[i] <= 1'b1;
        end
        if (captureEvent[i]) begin
          captureFlag[i] <= 1'b1;
        end else if (captureArmed[i] && captureLowRead[i]) begin
          captureFlag[i]  <= 1'b0;
          captureArmed[i] <= 1'b0;
        end else if (statusRead && captureFlag[i]) begin
          captureArmed[i] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // output compare
  // ------------------------------------------------------------
  // match checked once per new count, offset by the clock source
  always_comb begin
    for (int i = 0; i < FRT_CHANNELS; i++) begin
      if (timerClockSelect == FRT_CLK_DIV2) begin
        compareMatch[i] = countStep && (count == compareValue[i]);
      end else begin
        compareMatch[i] = countStep && (count == compareValue[i] + 16'h0001);
      end
      compareMatch[i] = compareMatch[i] && !compareInhibit[i];
    end
  end

  // compare registers only change by software writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < FRT_CHANNELS; i++) begin
        compareValue[i] <= FRT_COMPARE_RESET;
      end
      compareInhibit <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < FRT_CHANNELS; i++) begin
        if (compareHighWrite[i]) begin
          compareValue[i][15:8] <= writeData;
          compareInhibit[i]     <= 1'b1;
        end
        if (compareLowWrite[i]) begin
          compareValue[i][7:0] <= writeData;
          compareInhibit[i]    <= 1'b0;
        end
      end
    end
  end

  // compare flags; pwm blocks both, one-pulse blocks channel one
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      compareFlag  <= 2'h0;
      compareArmed <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < FRT_CHANNELS; i++) begin
        if (compareMatch[i] && !pwmMode && !(onePulseMode && i == 0)) begin
          compareFlag[i] <= 1'b1;
        end else if (compareLowWrite[i]) begin
          compareFlag[i]  <= 1'b0;
          compareArmed[i] <= 1'b0;
        end else if (compareArmed[i] && compareLowRead[i]) begin
          compareFlag[i]  <= 1'b0;
          compareArmed[i] <= 1'b0;
        end else if (statusRead && compareFlag[i]) begin
          compareArmed[i] <= 1'b1;
        end
      end
    end
  end

  // pin latch: low in reset, follows level on match or force
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      compareOutputPin <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < FRT_CHANNELS; i++) begin
        if (compareMatch[i] && comparePinEnable[i]) begin
          compareOutputPin[i] <= compareOutputLevel[i];
        end else if (forceLevelBit[i] && !onePulseMode && !pwmMode) begin
          compareOutputPin[i] <= compareOutputLevel[i];
        end
      end
    end
  end

  // pin is general I/O unless the channel owns it
  assign compareOutputOe = comparePinEnable;

  // ------------------------------------------------------------
  // interrupt request
  // ------------------------------------------------------------
  // pending flags wait for their enable and a clear mask
  assign timerIrq = !globalIrqMask && ((wrapFlag && wrapIrqEnable)
                    || ((|captureFlag) && captureIrqEnable)
                    || ((|compareFlag) && compareIrqEnable));

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_comb begin
    statusByte = 8'h00;
    statusByte[FRT_ST_CAPTURE1] = captureFlag[0];
    statusByte[FRT_ST_COMPARE1] = compareFlag[0];
    statusByte[FRT_ST_WRAP]     = wrapFlag;
    statusByte[FRT_ST_CAPTURE2] = captureFlag[1];
    statusByte[FRT_ST_COMPARE2] = compareFlag[1];
  end

  // registered byte of whichever register was read
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      readData  <= 8'h00;
      readValid <= 1'b0;
    end else if (ce) begin
      readValid <= statusRead | countHighRead | countLowRead | shadowHighRead
                   | shadowLowRead | (|captureHighRead) | (|captureLowRead)
                   | (|compareHighRead) | (|compareLowRead);
      if (statusRead) begin
        readData <= statusByte;
      end else if (countHighRead || shadowHighRead) begin
        readData <= highByte(count);
      end else if (countLowRead) begin
        readData <= countBufValid ? countLowBuf : lowByte(count);
      end else if (shadowLowRead) begin
        readData <= shadowBufValid ? shadowLowBuf : lowByte(count);
      end else if (captureHighRead[0]) begin
        readData <= highByte(captureValue[0]);
      end else if (captureHighRead[1]) begin
        readData <= highByte(captureValue[1]);
      end else if (captureLowRead[0]) begin
        readData <= lowByte(captureValue[0]);
      end else if (captureLowRead[1]) begin
        readData <= lowByte(captureValue[1]);
      end else if (compareHighRead[0]) begin
        readData <= highByte(compareValue[0]);
      end else if (compareHighRead[1]) begin
        readData <= highByte(compareValue[1]);
      end else if (compareLowRead[0]) begin
        readData <= lowByte(compareValue[0]);
      end else if (compareLowRead[1]) begin
        readData <= lowByte(compareValue[1]);
      end
    end
  end

endmodule
`default_nettype wire

/* tb/frt_timer_chk.sv */
// port assertions for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module frt_timer_chk (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       globalIrqMask,
  input wire logic       wrapIrqEnable,
  input wire logic       captureIrqEnable,
  input wire logic       compareIrqEnable,
  input wire logic [1:0] comparePinEnable,
  input wire logic       countLowRead,
  input wire logic       countLowWrite,
  input wire logic       shadowLowRead,
  input wire logic [1:0] compareLowRead,
  input wire logic [1:0] compareLowWrite,
  input wire logic       wrapFlag,
  input wire logic [1:0] captureFlag,
  input wire logic [1:0] compareFlag,
  input wire logic       timerIrq,
  input wire logic [1:0] compareOutputOe
);
  // ----------------------------
  // interrupt and flag relations
  // ----------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_irq_masked: assert property (globalIrqMask |-> !timerIrq)
    else $error("irq while masked");
  a_wrap_irq: assert property (wrapFlag && wrapIrqEnable && !globalIrqMask
    |-> timerIrq) else $error("wrap irq missing");
  a_cap_irq: assert property (|captureFlag && captureIrqEnable && !globalIrqMask
    |-> timerIrq) else $error("capture irq missing");
  a_cmp_irq: assert property (|compareFlag && compareIrqEnable && !globalIrqMask
    |-> timerIrq) else $error("compare irq missing");
  a_irq_cause: assert property (timerIrq |-> wrapFlag && wrapIrqEnable
    || |captureFlag && captureIrqEnable || |compareFlag && compareIrqEnable)
    else $error("irq without cause");
  a_wrap_clear: assert property ($fell(wrapFlag)
    |-> $past(countLowRead) || $past(countLowWrite)) else $error("wrap flag cleared early");
  a_shadow_keep: assert property (wrapFlag && shadowLowRead && !countLowRead
    && !countLowWrite |=> wrapFlag) else $error("shadow access cleared wrap flag");
  a_cmp_clear: assert property ($fell(compareFlag[0])
    |-> $past(compareLowRead[0]) || $past(compareLowWrite[0]))
    else $error("compare flag cleared early");
  a_pin_owner: assert property (compareOutputOe == comparePinEnable)
    else $error("pin enable not followed");
endmodule
bind frt_timer frt_timer_chk chk_u (.*);
`default_nettype wire

/* tb/frt_pin_model.sv */
// far-side pins: external count clock and capture inputs
`timescale 1ns/1ps
`default_nettype none
module frt_pin_model (
  input  wire logic       core_clk,         // core clock
  output logic            extCountClockPin, // low outside bursts
  output logic      [1:0] captureInputPin   // idle low
);
  // ----------------------------
  // pin drivers
  // ----------------------------
  initial begin
    extCountClockPin = 1'b0;
    captureInputPin = 2'h0;
  end
  // n periods, edges four core cycles apart
  task automatic burst(input int n);
    repeat (2 * n) begin
      @(posedge core_clk) #1 extCountClockPin = ~extCountClockPin;
      repeat (3) @(posedge core_clk);
    end
  endtask
  // one high pulse on capture pin i
  task automatic cap(input int i);
    @(posedge core_clk) #1 captureInputPin[i] = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 captureInputPin[i] = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
endmodule
`default_nettype wire

/* tb/frt_timer_tb.sv */
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module frt_timer_tb;
  import frt_pkg::*;
  localparam int STS = 0, CHI = 1, CLO = 2, CWR = 3, SHI = 4, SLO = 5, SWR = 6;
  localparam int PHI = 7, PLO = 9, QHI = 11, QLO = 13, WHI = 15, WLO = 17, FRC = 19;
  logic core_clk, rst_n, haltMode, globalIrqMask, extEdgePolarity, extCountClockPin;
  logic wrapIrqEnable, captureIrqEnable, compareIrqEnable, readValid, wrapFlag, timerIrq;
  logic [1:0] timerClockSelect, captureEdgeSelect, comparePinEnable, compareOutputLevel;
  logic [1:0] captureInputPin, captureFlag, compareFlag, compareOutputPin, compareOutputOe;
  logic [7:0] writeData, readData, flg;
  logic onePulseMode, pwmMode, vld; // vld: readValid one cycle after a strobe
  logic [20:0] st; // one bit per register strobe
  int failures = 0;
  int checked = 0;
  assign flg = {wrapFlag, captureFlag, compareFlag, compareOutputPin, timerIrq};
  frt_pin_model pm_u (.*);
  frt_timer dut_u (.*, .ce(1'b1),
    .statusRead(st[0]), .countHighRead(st[1]), .countLowRead(st[2]),
    .countLowWrite(st[3]), .shadowHighRead(st[4]), .shadowLowRead(st[5]),
    .shadowLowWrite(st[6]), .captureHighRead(st[8:7]), .captureLowRead(st[10:9]),
    .compareHighRead(st[12:11]), .compareLowRead(st[14:13]),
    .compareHighWrite(st[16:15]), .compareLowWrite(st[18:17]), .forceLevelBit(st[20:19]));
  // ----------------------------
  // tasks
  // ----------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // strobe taken at next edge, then one idle cycle
  task automatic op(input int b, input logic [7:0] d);
    st[b] = 1'b1;
    writeData = d;
    @(posedge core_clk) #1 st = '0;
    vld = readValid;
    @(posedge core_clk) #1;
  endtask
  task automatic rdb(input int b, input logic [7:0] e);
    op(b, 8'h00);
    chk({7'h00, vld}, 8'h01);
    chk(readData, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic give_verdict();
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    failures++;
    give_verdict();
  end
  // ----------------------------
  // scenarios
  // ----------------------------
  initial begin
    {rst_n, haltMode, extEdgePolarity, wrapIrqEnable, compareIrqEnable} = 5'h00;
    {onePulseMode, pwmMode} = 2'h0;
    {globalIrqMask, captureIrqEnable, captureEdgeSelect} = 4'hf;
    {comparePinEnable, compareOutputLevel} = 4'h7;
    timerClockSelect = FRT_CLK_EXT;
    st = '0;
    writeData = 8'h00;
    tick(5);
    rst_n = 1'b1;
    chk(flg, 8'h00);
    globalIrqMask = 1'b0;
    for (int i = 0; i < 2; i++) begin
      rdb(QHI + i, 8'h80);
      pm_u.cap(i);
      chk(flg, (8'h20 << i) | 8'h01);
      rdb(PHI + i, 8'hff);
      rdb(PLO + i, 8'hfc);
      chk(flg, (8'h20 << i) | 8'h01);
      op(STS, 8'h00);
      op(PLO + i, 8'h00);
      chk(flg, 8'h00);
      rdb(PHI + i, 8'hff);
      pm_u.cap(i);
      chk(flg, 8'h00);
      rdb(PLO + i, 8'hfc);
    end
    globalIrqMask = 1'b1;
    wrapIrqEnable = 1'b1;
    rdb(CHI, 8'hff);
    timerClockSelect = FRT_CLK_DIV2;
    tick(20);
    rdb(CHI, 8'h00);
    rdb(CLO, 8'hfc);
    chk(flg, 8'h80);
    globalIrqMask = 1'b0;
    tick(1);
    chk(flg, 8'h81);
    op(STS, 8'h00);
    op(SLO, 8'h00);
    chk(flg, 8'h81);
    op(CLO, 8'h00);
    chk(flg, 8'h00);
    timerClockSelect = FRT_CLK_EXT;
    wrapIrqEnable = 1'b0;
    op(SWR, 8'h00);
    rdb(SHI, 8'hff);
    rdb(SLO, 8'hfc);
    rdb(CLO, 8'hfc);
    op(WHI, 8'h00);
    op(WLO, 8'h10);
    op(WHI + 1, 8'h00);
    compareIrqEnable = 1'b1;
    timerClockSelect = FRT_CLK_DIV2;
    tick(60);
    chk(flg, 8'h8b);
    op(WLO + 1, 8'h30);
    tick(60);
    chk(flg, 8'h9b);
    op(STS, 8'h00);
    op(QLO, 8'h00);
    op(WLO + 1, 8'h30);
    chk(flg, 8'h82);
    compareOutputLevel = 2'h0;
    op(FRC, 8'h00);
    chk(flg, 8'h80);
    timerClockSelect = FRT_CLK_EXT;
    for (int p = 0; p < 2; p++) begin
      extEdgePolarity = p[0];
      op(CWR, 8'h00);
      haltMode = 1'b1;
      pm_u.burst(2);
      tick(4);
      haltMode = 1'b0;
      pm_u.burst(5);
      tick(4);
      rdb(CHI, 8'h00);
      rdb(CLO, 8'h01);
    end
    // slow clocks match one count late: count still shows compare plus one
    timerClockSelect = FRT_CLK_DIV8;
    wait (compareFlag[0]);
    #1;
    rdb(CHI, 8'h00);
    rdb(CLO, 8'h11);
    timerClockSelect = FRT_CLK_DIV4;
    wait (compareFlag[1]);
    #1;
    rdb(CHI, 8'h00);
    rdb(CLO, 8'h31);
    // pwm ignores the force bit, one-pulse keeps only capture two
    compareOutputLevel = 2'h3;
    pwmMode = 1'b1;
    op(FRC, 8'h00);
    chk(flg, 8'h99);
    {onePulseMode, pwmMode} = 2'h2;
    pm_u.cap(0);
    chk(flg, 8'h99);
    pm_u.cap(1);
    chk(flg, 8'hd9);
    give_verdict();
  end
endmodule
`default_nettype wire
